// *** iol_far_side_model.sv ***
// far-side model of the io-link devices
`timescale 1ns/1ps
module iol_far_side_model (
   input wire ref_clk, // clock
   input wire rst_b, // reset, active low
   input wire slow, // answer uploads late
   input wire lockSet, // restore lock
   input wire differSet, // params differ
   input wire [7:0] cmdStb, // command strobe
   input wire [15:0] cmdIdx, // command index
   input wire [7:0] cmdSub, // command subindex
   input wire [7:0] cmdVal, // command value
   input wire [7:0] uploadReq, // upload request
   output wire [7:0] dsUploadFlag, // upload flag
   output wire [7:0] devAccessLock, // access lock
   output wire [7:0] devParamDiffer, // differ
   output wire [7:0] uploadDone // upload stored
);
   reg [7:0] flag_ff;
   reg [7:0] pend_ff;
   reg [7:0] done_ff;
   reg [2:0] wait_ff;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_ff <= 8'h00;
         pend_ff <= 8'h00;
         done_ff <= 8'h00;
         wait_ff <= 3'h0;
      end else begin
         flag_ff <= (cmdIdx == 16'h0002 && cmdSub == 8'h00 &&
            cmdVal == 8'h05) ? cmdStb : 8'h00;
         done_ff <= 8'h00;
         if (uploadReq != 8'h00) begin
            pend_ff <= uploadReq;
            // slow device: late upload
            wait_ff <= slow ? 3'h4 : 3'h0;
         end else if (wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
         end else begin
            done_ff <= pend_ff;
            pend_ff <= 8'h00;
         end
      end
   end
   assign dsUploadFlag = flag_ff;
   assign uploadDone = done_ff;
   assign devAccessLock = {8{lockSet}};
   assign devParamDiffer = {8{differSet}};
endmodule

// *** iol_port_out_image.v ***
// per-port io-link configuration, data storage control and output image unpacking
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "iol_port_out_image_defines.vh"
// What this block does
// (RULE1) deactivated port stays inactive, keeps config, raises no diagnostics
// (RULE2) autostart activates port, ignores validation, ids and cycle time
// (RULE3) manual activates port and applies validation, ids and cycle time
// (RULE4) validation and backup honoured only in manual mode
// (RULE5) backup invalidated on factory reset, mode change, validation change; an upload finishing in the same cycle sets it valid instead
// (RULE6) no-device-check skips id check, no backup or restore
// (RULE7) v1.0 setting checks ids, no parameter server
// (RULE8) v1.1 without storage checks ids, backup and restore disabled
// (RULE9) backup mode uploads on connect when no valid set is held
// (RULE10) backup mode uploads whenever device raises its upload flag
// (RULE11) operator's store command 0x05 at index 2 requests upload
// (RULE12) restore-capable modes download a valid differing set on connect
// (RULE13) restore blocked when device access lock forbids it
// (RULE14) restore-only never stores; upload flag triggers a download instead
// (RULE15) expected ids used only in manual mode with a v1.x check
// (RULE16) manual cycle is fastest or one fixed period 1.6 to 120 ms
// (RULE17) image is header, 2 do bytes, 2 reserved, 0..256 io-link bytes
// (RULE18) do bits apply only to output channels with direct control
// (RULE19) io-link data split into port fields of 0..32 bytes in order
// (RULE20) port fields reserved regardless of channel mode
// (RULE21) each field forwarded after its swapping mode and offset
// (RULE22) no io-link port means no io-link data section
// (RULE23) port parameters ignored unless channel mode is io-link
// (RULE24) word swaps byte pairs, dword reverses four, raw unchanged
// (RULE25) data size changes accepted only with no fieldbus connection
// (RULE26) ports inactive until configured; no output data before valid image; io-link bytes leave on iolWrValid before the frame length is checked
module iol_port_out_image #(
   parameter NPORT = 8,
   parameter NCHAN = 16
) (
   input wire ref_clk, // system clock
   input wire rst_b, // async reset, active low
   input wire hsel, // ahb select
   input wire [31:0] haddr, // ahb address
   input wire [1:0] htrans, // ahb transfer type
   input wire hwrite, // ahb write
   input wire [2:0] hsize, // ahb size, word only
   input wire [31:0] hwdata, // ahb write data
   input wire hready, // ahb bus ready
   output reg [31:0] hrdata, // ahb read data
   output reg hreadyout, // ahb slave ready
   output reg hresp, // ahb response, always okay
   input wire connActive, // fieldbus connection up
   input wire factoryReset, // factory reset pulse
   input wire imgValid, // output image byte valid
   input wire imgSof, // first byte of image
   input wire imgEof, // last byte of image
   input wire [7:0] imgData, // image byte
   input wire [NPORT-1:0] devConnect, // device connected pulse
   input wire [NPORT-1:0] dsUploadFlag, // device upload flag seen pulse
   input wire [NPORT-1:0] devParamDiffer, // stored set differs from device
   input wire [NPORT-1:0] devAccessLock, // device forbids restore
   input wire [NPORT-1:0] uploadDone, // upload stored in nv memory
   output reg [NPORT-1:0] portActive, // port activated, diagnostics on
   output reg [NPORT-1:0] idCheck, // compare vendor and device ids
   output reg [NPORT*16-1:0] expVendor, // expected vendor ids
   output reg [NPORT*24-1:0] expDevice, // expected device ids
   output reg [NPORT*4-1:0] cycleSel, // cycle selection, 0 fastest
   output reg [NPORT-1:0] uploadReq, // start parameter upload pulse
   output reg [NPORT-1:0] downloadReq, // start parameter download pulse
   output reg [NPORT-1:0] restoreBlocked, // last restore refused by lock
   output reg [NCHAN-1:0] doOut, // digital output controls
   output reg [NPORT-1:0] portDataValid, // valid image seen for port
   output reg iolWrValid, // io-link output byte pulse
   output reg [2:0] iolWrPort, // target port
   output reg [4:0] iolWrIdx, // byte index in device data
   output reg [7:0] iolWrData // byte value
);

   reg [`PCFG_W-1:0] pcfg_ff [0:NPORT-1];
   reg [15:0] vid_ff [0:NPORT-1];
   reg [23:0] did_ff [0:NPORT-1];
   reg [NCHAN-1:0] chanOut_ff;
   reg doDirect_ff;

   reg [NPORT-1:0] chanIol_ff;
   reg [NPORT-1:0] loaded_ff;
   reg [NPORT-1:0] nvValid_ff;
   reg wrPend_ff;
   reg rdPend_ff;

   reg [7:0] addr_ff;
   reg addrOk_ff;

   reg [8:0] cnt_ff;
   reg [15:0] doShadow_ff;
   reg run_ff;
   reg imgSeen_ff;
   reg lenErr_ff;

   wire addrPhase = hsel & htrans[1] & hready;
   wire wrEn = wrPend_ff & addrOk_ff;
   wire wrPcfg = wrEn & (addr_ff[7:5] == `REG_PCFG_BASE);
   wire [2:0] wrIdx = addr_ff[4:2];

   // field sizes and offsets, kept whatever the channel mode
   wire [5:0] fsz [0:NPORT-1];
   wire [8:0] base [0:NPORT-1];
   wire [NPORT-1:0] inv;
   wire [8:0] iolTotal = base[NPORT-1] + {3'h0, fsz[NPORT-1]};
   wire anyIol = |chanIol_ff;
   wire [8:0] expLen = `IMG_IOL_START + (anyIol ? iolTotal : 9'h000); // [RULE17] [RULE22]

   function [5:0] sizeBytes;
      input [2:0] code;
      begin
         case (code)
            3'h1: sizeBytes = 6'd2;
            3'h2: sizeBytes = 6'd4;
            3'h3: sizeBytes = 6'd8;
            3'h4: sizeBytes = 6'd16;
            3'h5: sizeBytes = 6'd32;
            default: sizeBytes = 6'd0;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NPORT; g = g + 1) begin : port
         wire [`PCFG_W-1:0] cfg = pcfg_ff[g];
         wire [1:0] mode = cfg[`PCFG_MODE_MSB:`PCFG_MODE_LSB];
         wire manual = (mode == `MODE_MANUAL);
         wire act = loaded_ff[g] & chanIol_ff[g] & (mode != `MODE_DEACT);
         // no check outside manual mode
         wire [2:0] valEff = manual ? cfg[`PCFG_VAL_MSB:`PCFG_VAL_LSB] :
                             `VAL_NOCHECK; // [RULE2] [RULE4]
         wire br = act & (valEff == `VAL_V11_BR);
         wire ro = act & (valEff == `VAL_V11_RO);

         // nocheck, v1.0 and v1.1 plain never reach br or ro
         wire wantUp = (devConnect[g] & br & ~nvValid_ff[g]) | // [RULE9]
                       (dsUploadFlag[g] & br); // [RULE10] [RULE11]
         wire cand = (devConnect[g] & (br | ro) & nvValid_ff[g] &
                      devParamDiffer[g]) | // [RULE12]
                     (dsUploadFlag[g] & ro & nvValid_ff[g]); // [RULE14]

         wire [3:0] cyc = cfg[`PCFG_CYC_MSB:`PCFG_CYC_LSB];
         assign fsz[g] = sizeBytes(cfg[`PCFG_SIZE_MSB:`PCFG_SIZE_LSB]);
         if (g == 0) begin : first
            assign base[g] = 9'h000;
         end else begin : next
            assign base[g] = base[g-1] + {3'h0, fsz[g-1]}; // [RULE19] [RULE20]
         end

         assign inv[g] = factoryReset |
            (wrPcfg & (wrIdx == g) &
             ((hwdata[`PCFG_MODE_MSB:`PCFG_MODE_LSB] != mode) |
              (hwdata[`PCFG_VAL_MSB:`PCFG_VAL_LSB] !=
               cfg[`PCFG_VAL_MSB:`PCFG_VAL_LSB]))) |
            (wrEn & (addr_ff == `REG_CHIOL) &
             (hwdata[g] != chanIol_ff[g])); // [RULE5]

         always @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               portActive[g] <= 1'b0;
               idCheck[g] <= 1'b0;
               cycleSel[g*4 +: 4] <= 4'h0;
               uploadReq[g] <= 1'b0;
               downloadReq[g] <= 1'b0;
               restoreBlocked[g] <= 1'b0;
               nvValid_ff[g] <= 1'b0;
               expVendor[g*16 +: 16] <= 16'h0000;
               expDevice[g*24 +: 24] <= 24'h000000;
            end else begin
               // deactivated ports stay quiet
               portActive[g] <= act; // [RULE1] [RULE2] [RULE3] [RULE23] [RULE26]
               idCheck[g] <= act & manual &
                  (valEff != `VAL_NOCHECK) &
                  (valEff <= `VAL_V11_RO); // [RULE6] [RULE7] [RULE8] [RULE15]
               expVendor[g*16 +: 16] <= vid_ff[g]; // [RULE3]
               expDevice[g*24 +: 24] <= did_ff[g]; // [RULE3]
               // out-of-range selections fall back to fastest
               cycleSel[g*4 +: 4] <= (act & manual & (cyc <= `CYC_MAX_SEL)) ?
                  cyc : `CYC_FASTEST; // [RULE16]
               uploadReq[g] <= wantUp; // [RULE6] [RULE7] [RULE8]
               downloadReq[g] <= cand & ~devAccessLock[g]; // [RULE13]
               if (cand & devAccessLock[g])
                  restoreBlocked[g] <= 1'b1; // [RULE13]
               else if (devConnect[g])
                  restoreBlocked[g] <= 1'b0;
               // a finished upload beats a same-cycle invalidation
               if (uploadDone[g] & br)
                  nvValid_ff[g] <= 1'b1; // [RULE9]
               else if (inv[g])
                  nvValid_ff[g] <= 1'b0; // [RULE5]
            end
         end
      end
   endgenerate

   // configuration registers
   integer k;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (k = 0; k < NPORT; k = k + 1) begin
            pcfg_ff[k] <= `PCFG_RESET;
            vid_ff[k] <= 16'h0000;
            did_ff[k] <= 24'h000000;
         end
         chanOut_ff <= {NCHAN{1'b0}};
         doDirect_ff <= 1'b0;
         chanIol_ff <= {NPORT{1'b0}};
         loaded_ff <= {NPORT{1'b0}};
      end else if (wrEn) begin
         if (addr_ff == `REG_DOCFG) begin
            chanOut_ff <= hwdata[NCHAN-1:0];
            doDirect_ff <= hwdata[`DOCFG_DIRECT_BIT];
         end
         if (addr_ff == `REG_CHIOL)
            chanIol_ff <= hwdata[NPORT-1:0];
         if (wrPcfg) begin
            pcfg_ff[wrIdx] <= hwdata[`PCFG_W-1:0];
            loaded_ff[wrIdx] <= 1'b1; // [RULE26]
            // size frozen while the fieldbus runs
            if (connActive)
               pcfg_ff[wrIdx][`PCFG_SIZE_MSB:`PCFG_SIZE_LSB] <=
                  pcfg_ff[wrIdx][`PCFG_SIZE_MSB:`PCFG_SIZE_LSB]; // [RULE25]
         end
         if (addr_ff[7:5] == `REG_VID_BASE)
            vid_ff[wrIdx] <= hwdata[15:0];
         if (addr_ff[7:5] == `REG_DID_BASE)
            did_ff[wrIdx] <= hwdata[23:0];
      end
   end

   // ahb-lite slave: writes no wait, reads one
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h00000000;
      if (addrOk_ff) begin
         case (addr_ff[7:5])
            3'b000: begin
               case (addr_ff[4:2])
                  3'h0: rdMux = {15'h0000, doDirect_ff, chanOut_ff};
                  3'h1: rdMux = {24'h000000, chanIol_ff};
                  3'h2: rdMux = {13'h0000, lenErr_ff, run_ff, imgSeen_ff,
                                 restoreBlocked, nvValid_ff};
                  3'h3: rdMux = {16'h0000, doOut};
                  default: rdMux = 32'h00000000;
               endcase
            end
            `REG_PCFG_BASE: rdMux = {13'h0000, pcfg_ff[addr_ff[4:2]]};
            `REG_VID_BASE: rdMux = {16'h0000, vid_ff[addr_ff[4:2]]};
            `REG_DID_BASE: rdMux = {8'h00, did_ff[addr_ff[4:2]]};
            default: rdMux = 32'h00000000;
         endcase
      end
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPend_ff <= 1'b0;
         rdPend_ff <= 1'b0;
         addr_ff <= 8'h00;
         addrOk_ff <= 1'b0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (rdPend_ff) begin
            hrdata <= rdMux;
            hreadyout <= 1'b1;
            rdPend_ff <= 1'b0;
            wrPend_ff <= 1'b0;
         end else if (addrPhase) begin
            addr_ff <= haddr[7:0];
            // unmapped addresses read zero and drop writes
            addrOk_ff <= (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
            wrPend_ff <= hwrite;
            rdPend_ff <= ~hwrite;
            hreadyout <= hwrite;
         end else begin
            wrPend_ff <= 1'b0;
         end
      end
   end

   // output image unpacking
   wire [8:0] pos = imgSof ? 9'h000 : cnt_ff;
   wire [8:0] iolOff = pos - `IMG_IOL_START;

   reg hit;
   reg [2:0] hitPort;
   reg [5:0] hitIdx;
   reg [5:0] dest;
   reg [5:0] swOff;
   reg [5:0] rel;
   reg [5:0] grp;
   reg [1:0] swMode;

   integer p;
   always @* begin
      hit = 1'b0;
      hitPort = 3'h0;
      hitIdx = 6'h00;
      for (p = 0; p < NPORT; p = p + 1) begin
         if (iolOff >= base[p] && iolOff < base[p] + {3'h0, fsz[p]}) begin
            hit = 1'b1; // [RULE19]
            hitPort = p[2:0];
            hitIdx = iolOff[5:0] - base[p][5:0];
         end
      end
      if (pos < `IMG_IOL_START || !anyIol)
         hit = 1'b0; // [RULE22]

      swMode = pcfg_ff[hitPort][`PCFG_SWAP_MSB:`PCFG_SWAP_LSB];
      swOff = {1'b0, pcfg_ff[hitPort][`PCFG_SWOFF_MSB:`PCFG_SWOFF_LSB]};
      grp = (swMode == `SWAP_WORD) ? 6'h01 :
            (swMode == `SWAP_DWORD) ? 6'h03 : 6'h00; // [RULE24]

      rel = hitIdx - swOff;
      dest = hitIdx;
      // only whole groups that fit the field are reordered
      if (grp != 6'h00 && hitIdx >= swOff &&
          swOff + (rel | grp) < fsz[hitPort])
         dest = swOff + (rel ^ grp); // [RULE21] [RULE24]
   end

   integer c;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 9'h000;
         doShadow_ff <= 16'h0000;
         run_ff <= 1'b0;
         imgSeen_ff <= 1'b0;
         lenErr_ff <= 1'b0;
         doOut <= {NCHAN{1'b0}};
         portDataValid <= {NPORT{1'b0}};
         iolWrValid <= 1'b0;
         iolWrPort <= 3'h0;
         iolWrIdx <= 5'h00;
         iolWrData <= 8'h00;
      end else begin
         iolWrValid <= 1'b0;
         if (imgValid) begin
            // saturate so a runaway frame never wraps into the header
            if (pos != 9'h1ff)
               cnt_ff <= pos + 9'h001;
            if (pos == 9'h000)
               run_ff <= imgData[0];
            if (pos == `IMG_DO_LO)
               doShadow_ff[7:0] <= imgData; // [RULE17]
            if (pos == `IMG_DO_HI)
               doShadow_ff[15:8] <= imgData; // [RULE17]
            // non io-link ports keep their slot, get nothing
            if (hit && chanIol_ff[hitPort]) begin // [RULE20] [RULE23]
               iolWrValid <= 1'b1; // [RULE21]
               iolWrPort <= hitPort;
               iolWrIdx <= dest[4:0];
               iolWrData <= imgData;
            end

            if (imgEof) begin
               if (pos + 9'h001 == expLen) begin // [RULE17]
                  imgSeen_ff <= 1'b1;
                  lenErr_ff <= 1'b0;
                  portDataValid <= chanIol_ff; // [RULE26]
                  for (c = 0; c < NCHAN; c = c + 1)
                     doOut[c] <= chanOut_ff[c] & doDirect_ff &
                                 (pos == `IMG_DO_HI ? (c >= 8 ? imgData[c-8] :
                                  doShadow_ff[c]) : doShadow_ff[c]); // [RULE18]
               end else begin
                  lenErr_ff <= 1'b1;
               end
            end
         end
      end
   end

endmodule

// *** iol_port_out_image_checker.sv ***
// assertions on the port and image block
`timescale 1ns/1ps
module iol_port_out_image_checker #(
   parameter NPORT = 8,
   parameter NCHAN = 16
) (
   input wire ref_clk, // clock
   input wire rst_b, // reset, active low
   input wire hsel, // ahb select
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write
   input wire hready, // bus ready
   input wire hreadyout, // slave ready
   input wire imgValid, // image byte valid
   input wire imgEof, // last image byte
   input wire [NPORT-1:0] devConnect, // device connected
   input wire [NPORT-1:0] dsUploadFlag, // upload flag seen
   input wire [NPORT-1:0] devAccessLock, // restore lock
   input wire [NPORT-1:0] portActive, // port active
   input wire [NPORT-1:0] idCheck, // id compare on
   input wire [NPORT-1:0] uploadReq, // upload pulse
   input wire [NPORT-1:0] downloadReq, // download pulse
   input wire [NPORT-1:0] restoreBlocked, // restore refused
   input wire [NCHAN-1:0] doOut, // digital outputs
   input wire [NPORT-1:0] portDataValid, // image seen per port
   input wire iolWrValid // io-link byte pulse
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   rd_wait_a: assert property (hsel && htrans[1] && !hwrite && hready
      |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   up_cause_a: assert property (uploadReq != 0
      |-> $past((devConnect | dsUploadFlag) != 0)) else $error("stray upload");
   dn_cause_a: assert property (downloadReq != 0
      |-> $past((devConnect | dsUploadFlag) != 0)) else $error("stray restore");
   up_dn_excl_a: assert property ((uploadReq & downloadReq) == 0)
      else $error("upload with restore");
   lock_dl_a: assert property ((downloadReq & devAccessLock) == 0)
      else $error("restore despite lock");
   id_active_a: assert property ((idCheck & ~portActive) == 0)
      else $error("id check on inactive port");
   wr_cause_a: assert property (iolWrValid |-> $past(imgValid))
      else $error("stray io-link byte");
   do_hold_a: assert property (!$past(imgValid && imgEof)
      |-> $stable(doOut)) else $error("outputs moved mid frame");
   pdv_cause_a: assert property ((portDataValid & ~$past(portDataValid))
      != 0 |-> $past(imgValid && imgEof)) else $error("data valid early");
   blk_cause_a: assert property ((restoreBlocked & ~$past(restoreBlocked))
      != 0 |-> $past((devConnect | dsUploadFlag) != 0))
      else $error("blocked without event");

   up_c: cover property (uploadReq != 0);
   dn_c: cover property (downloadReq != 0);
   wr_c: cover property (iolWrValid);
endmodule

bind iol_port_out_image iol_port_out_image_checker #(.NPORT(NPORT),
   .NCHAN(NCHAN)) chk (.*);

// *** iol_port_out_image_defines.vh ***
// offsets, fields, encodings and frame layout
`ifndef IOL_PORT_OUT_IMAGE_DEFINES_VH
`define IOL_PORT_OUT_IMAGE_DEFINES_VH

// register byte offsets
`define REG_DOCFG 8'h00
`define REG_CHIOL 8'h04
`define REG_STATUS 8'h08
`define REG_DOOUT 8'h0c
`define REG_PCFG_BASE 3'b010
`define REG_VID_BASE 3'b100
`define REG_DID_BASE 3'b101

// docfg fields
`define DOCFG_DIRECT_BIT 16

// per-port configuration fields
`define PCFG_MODE_LSB 0
`define PCFG_MODE_MSB 1
`define PCFG_VAL_LSB 2
`define PCFG_VAL_MSB 4
`define PCFG_CYC_LSB 5
`define PCFG_CYC_MSB 8
`define PCFG_SIZE_LSB 9
`define PCFG_SIZE_MSB 11
`define PCFG_SWAP_LSB 12
`define PCFG_SWAP_MSB 13
`define PCFG_SWOFF_LSB 14
`define PCFG_SWOFF_MSB 18
`define PCFG_W 19
`define PCFG_RESET 19'h00000

// port modes
`define MODE_DEACT 2'h0
`define MODE_AUTO 2'h1
`define MODE_MANUAL 2'h2

// validation and backup levels
`define VAL_NOCHECK 3'h0
`define VAL_V10 3'h1
`define VAL_V11 3'h2
`define VAL_V11_BR 3'h3
`define VAL_V11_RO 3'h4

// cycle time selections, 0 is fastest
`define CYC_FASTEST 4'h0
`define CYC_MAX_SEL 4'h8

// swapping modes
`define SWAP_RAW 2'h0
`define SWAP_WORD 2'h1
`define SWAP_DWORD 2'h2

// output frame layout
`define IMG_DO_LO 9'h004
`define IMG_DO_HI 9'h005
`define IMG_IOL_START 9'h008

`endif

// *** iol_port_out_image_tb_top.sv ***
// self-checking bench for the port and image block
`timescale 1ns/1ps
`include "iol_port_out_image_defines.vh"
module iol_port_out_image_tb_top;
   logic ref_clk, rst_b, hsel, hwrite, connActive, factoryReset, hresp;
   logic imgValid, imgSof, imgEof, slow, lockSet, differSet, hreadyout;
   logic [31:0] haddr, hwdata, hrdata, q, cycleSel;
   logic [1:0] htrans;
   logic [2:0] hsize, iolWrPort;
   logic [7:0] imgData, devConnect, cmdStb, up, dn, cmdSub, cmdVal;
   logic [7:0] dsUploadFlag, devParamDiffer, devAccessLock, uploadDone;
   logic [7:0] portActive, idCheck, uploadReq, downloadReq, restoreBlocked;
   logic [7:0] portDataValid, iolWrData;
   logic [127:0] expVendor;
   logic [191:0] expDevice;
   logic [15:0] doOut, cmdIdx;
   logic [4:0] iolWrIdx;
   logic iolWrValid;
   logic [15:0] wq[$];
   wire hready = hreadyout;
   int bad_count = 0, num_checks = 0, cycles = 0;
   iol_port_out_image #(.NPORT(8), .NCHAN(16)) dut (.*);
   iol_far_side_model far (.*);

   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         $display("MISMATCH %0t timeout", $time);
         test_done();
      end
   end

   task automatic cmpOut(input logic [63:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, d);
      @(posedge ref_clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hready !== 1'h1) @(posedge ref_clk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hready !== 1'h1) @(posedge ref_clk);
      q = hrdata;
   endtask

   function automatic logic [31:0] pw(input logic [1:0] m,
      input logic [2:0] v, input logic [3:0] c, input logic [2:0] s,
      input logic [1:0] w);
      return {18'h0, w, s, c, v, m};
   endfunction

   task automatic cfg(input int p, input logic [31:0] w);
      bus(1'h1, 32'h40 + 4 * p, w);
      tick(3);
   endtask

   task automatic ev(input logic cmd);
      {up, dn} = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         devConnect <= (i == 0 && !cmd) ? 8'h01 : 8'h00;
         cmdStb <= (i == 0 && cmd) ? 8'h01 : 8'h00;
         #1;
         up = up | uploadReq;
         dn = dn | downloadReq;
      end
      tick(8);
   endtask

   task automatic frame(input logic [7:0] b[$]);
      wq.delete();
      for (int i = 0; i <= b.size() + 2; i++) begin
         @(posedge ref_clk);
         imgValid <= i < b.size();
         imgSof <= i == 0;
         imgEof <= i == b.size() - 1;
         imgData <= i < b.size() ? b[i] : ~imgData;
         #1;
         if (iolWrValid === 1'h1) wq.push_back({iolWrPort, iolWrIdx, iolWrData});
      end
   endtask

   task automatic t_reset;
      tick(1);
      cmpOut({portActive, uploadReq, portDataValid, doOut}, 0, "rst out");
      cmpOut({hreadyout, iolWrValid, hresp}, 3'h4, "rst bus");
      bus(1'h0, 32'h08, 0);
      cmpOut(q, 0, "status");
      bus(1'h0, 32'hfc, 0);
      cmpOut(q, 0, "unmapped");
      $display("test reset done");
   endtask

   task automatic t_modes;
      bus(1'h1, 32'h04, 32'h0000_00fd);
      bus(1'h1, 32'h80, 32'h0000_1234);
      bus(1'h1, 32'ha0, 32'h0056_789a);
      cfg(0, pw(`MODE_DEACT, `VAL_V11, 4'h3, 3'h0, `SWAP_RAW));
      bus(1'h0, 32'h40, 0);
      cmpOut({portActive[0], q}, pw(0, 2, 3, 0, 0), "deact");
      cfg(0, pw(`MODE_AUTO, `VAL_V11, 4'h3, 3'h0, `SWAP_RAW));
      cmpOut({portActive[0], idCheck[0], cycleSel[3:0]}, 6'h20, "auto");
      for (int c = 0; c <= 8; c++) begin
         cfg(0, pw(`MODE_MANUAL, `VAL_V11, c[3:0], 3'h0, `SWAP_RAW));
         cmpOut({portActive[0], idCheck[0], cycleSel[3:0]}, {2'h3, c[3:0]},
            "manual");
      end
      cmpOut({expVendor[15:0], expDevice[23:0]}, 40'h1234_56789a, "ids");
      cfg(1, pw(`MODE_MANUAL, `VAL_NOCHECK, 4'h0, 3'h0, `SWAP_RAW));
      cmpOut(portActive[1], 0, "not io-link");
      $display("test modes done");
   endtask

   task automatic t_val;
      bus(1'h1, 32'h04, 32'h0000_00ff);
      for (int v = 0; v <= 4; v++) begin
         cfg(0, pw(`MODE_MANUAL, v[2:0], 4'h0, 3'h0, `SWAP_RAW));
         cmpOut(idCheck[0], v != 0, "id level");
         ev(1'h0);
         cmpOut({up[0], dn[0]}, {v == 3, 1'h0}, "no set");
         bus(1'h0, 32'h08, 0);
         cmpOut(q & 32'h1, v == 3, "set valid");
      end
      cfg(0, pw(`MODE_AUTO, `VAL_V11_BR, 4'h0, 3'h0, `SWAP_RAW));
      ev(1'h0);
      cmpOut(up[0], 0, "auto backup");
      $display("test validation done");
   endtask

   task automatic t_store;
      cfg(0, pw(`MODE_MANUAL, `VAL_V11_BR, 4'h0, 3'h0, `SWAP_RAW));
      slow = 1'h1;
      ev(1'h0);
      bus(1'h0, 32'h08, 0);
      cmpOut({up[0], q[0]}, 2'h3, "backup");
      ev(1'h1);
      cmpOut({up[0], dn[0]}, 2'h2, "store cmd");
      differSet = 1'h1;
      ev(1'h0);
      cmpOut({up[0], dn[0]}, 2'h1, "restore");
      lockSet = 1'h1;
      ev(1'h0);
      cmpOut({dn[0], restoreBlocked[0]}, 2'h1, "locked");
      @(posedge ref_clk);
      factoryReset <= 1'h1;
      @(posedge ref_clk);
      factoryReset <= 1'h0;
      bus(1'h0, 32'h08, 0);
      cmpOut(q & 32'h1, 0, "factory reset");
      lockSet = 1'h0;
      cfg(0, pw(`MODE_MANUAL, `VAL_V11_RO, 4'h0, 3'h0, `SWAP_RAW));
      ev(1'h1);
      cmpOut({up[0], dn[0]}, 2'h0, "restore only");
      $display("test storage done");
   endtask

   task automatic t_image;
      bus(1'h1, 32'h00, 32'h0001_00ff);
      bus(1'h1, 32'h04, 32'h0000_0001);
      cfg(0, pw(`MODE_MANUAL, `VAL_NOCHECK, 4'h0, 3'h1, `SWAP_WORD));
      frame('{8'h01, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h3c, 8'h00, 8'h00,
         8'h11, 8'h22});
      cmpOut({wq.size(), wq[0], wq[1]}, 64'h2_0111_0022, "word");
      cmpOut({doOut, portDataValid[0]}, 17'h0014b, "do mask");
      cfg(0, pw(`MODE_MANUAL, `VAL_NOCHECK, 4'h0, 3'h2, `SWAP_DWORD));
      cfg(1, pw(`MODE_MANUAL, `VAL_NOCHECK, 4'h0, 3'h1, `SWAP_RAW));
      frame('{8'h01, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00, 8'h00, 8'h00,
         8'h11, 8'h22, 8'h33, 8'h44, 8'h66, 8'h77});
      cmpOut({wq[0], wq[1], wq[2], wq[3]}, 64'h0311_0222_0133_0044,
         "dword");
      cmpOut(doOut, 16'h005a, "reserved");
      frame('{8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
         8'h11, 8'h22, 8'h33});
      bus(1'h0, 32'h08, 0);
      cmpOut({doOut, q[18]}, 17'h000b5, "bad length");
      bus(1'h1, 32'h04, 32'h0);
      frame('{8'h01, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hff, 8'h00, 8'h00});
      cmpOut(doOut, 16'h000f, "no io-link");
      @(posedge ref_clk);
      connActive <= 1'h1;
      cfg(0, pw(`MODE_MANUAL, `VAL_NOCHECK, 4'h5, 3'h5, `SWAP_RAW));
      bus(1'h0, 32'h40, 0);
      cmpOut(q, pw(`MODE_MANUAL, `VAL_NOCHECK, 4'h5, 3'h2, `SWAP_RAW),
         "size lock");
      $display("test image done");
   endtask

   initial begin
      {rst_b, hsel, hwrite, connActive, factoryReset} = 5'h0;
      {imgValid, imgSof, imgEof, slow, lockSet, differSet} = 6'h0;
      {haddr, hwdata, htrans, hsize} = 69'h2;
      {imgData, devConnect, cmdStb} = 24'h0;
      {cmdIdx, cmdSub, cmdVal} = 32'h0002_0005;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_reset();
      t_modes();
      t_val();
      t_store();
      t_image();
      test_done();
   end
endmodule
